// ### svt_deglitch.sv
/*
 * Two-flop synchroniser followed by a stability filter for one pin.
 * Assumes the pin is asynchronous to clk; output changes only after the
 * synchronised level has held for STABLE consecutive cycles.
 */
`timescale 1ns/1ps
module svt_deglitch #(
	parameter int   STABLE = 5,
	parameter logic INIT   = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin_in,
	output logic      level_out
);

	logic       meta_r;
	logic       sync_r;
	logic [7:0] stable_cnt_r;

	// Only the second flop reads the first one.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_r <= INIT;
			sync_r <= INIT;
		end else begin
			meta_r <= pin_in;
			sync_r <= meta_r;
		end
	end

	// A change must persist for STABLE cycles, so narrower pulses never pass.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			stable_cnt_r <= 8'h00;
			level_out    <= INIT;
		end else if (sync_r == level_out) begin
			stable_cnt_r <= 8'h00;
		end else if (stable_cnt_r >= 8'(STABLE - 1)) begin
			stable_cnt_r <= 8'h00;
			level_out    <= sync_r;
		end else begin
			stable_cnt_r <= stable_cnt_r + 8'h01;
		end
	end

endmodule

// ### svt_host.sv
/*
 * Behavioural host on the two-wire bus: start, address, data, stop, glitch.
 * Assumes the data line is pulled up and that callers enter its tasks
 * just after a rising clk edge.
 */
`timescale 1ns/1ps
module svt_host #(
	parameter int HP = 10
) (
	input wire logic clk,
	input wire logic sda_oe,
	output logic     scl,
	output logic     sda
);
	logic sda_drv = 1'b1;

	// The line is pulled up, so it is low only where some party pulls it.
	assign sda = sda_drv & ~sda_oe;
	initial scl = 1'b1;

	task automatic hw(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One byte MSB first, then the acknowledge clock with the line released.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= -1; i--) begin
			hw(2);
			sda_drv <= (i < 0) ? 1'b1 : b[i];
			hw(HP);
			scl <= 1'b1;
			hw(HP);
			ack = !sda;
			scl <= 1'b0;
		end
	endtask

	// A whole write; data is sent only when the address is acknowledged.
	task automatic xfer(input logic [7:0] a, input logic [7:0] d, output logic ack_a,
		output logic ack_d);
		sda_drv <= 1'b0;
		hw(100);
		scl <= 1'b0;
		put_byte(a, ack_a);
		ack_d = 1'b0;
		if (ack_a)
			put_byte(d, ack_d);
		hw(2);
		sda_drv <= 1'b0;
		hw(HP);
		scl <= 1'b1;
		hw(HP);
		sda_drv <= 1'b1;
		hw(HP);
	endtask

	task automatic glitch();
		sda_drv <= 1'b0;
		hw(2);
		sda_drv <= 1'b1;
	endtask
endmodule

// ### svt_pkg.sv
/*
 * Shared constants, encodings and helper functions of the supervisor timing block.
 * Assumes a single 100 MHz clock; every millisecond figure is counted in ticks of
 * a one-millisecond enable produced inside the top module.
 */
package svt_pkg;

	// Clock and tick timing.
	localparam int CLK_PERIOD_NS  = 10;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam int TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;

	// Input glitch suppression: a least time, rounded up to whole cycles.
	localparam int GLITCH_NS     = 50;
	localparam int GLITCH_CYCLES = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Millisecond counters.
	localparam int MS_W = 11;
	localparam logic [10:0] POR_MS_0        = 11'd50;
	localparam logic [10:0] POR_MS_1        = 11'd200;
	localparam logic [10:0] POR_MS_2        = 11'd400;
	localparam logic [10:0] POR_MS_3        = 11'd800;
	localparam logic [10:0] WDOG_MS_0       = 11'd1400;
	localparam logic [10:0] WDOG_MS_1       = 11'd200;
	localparam logic [10:0] WDOG_MS_2       = 11'd25;
	localparam logic [10:0] WDOG_RST1_MS    = 11'd200;
	localparam logic [10:0] WDOG_RST2_MS    = 11'd25;
	localparam logic [10:0] NV_WRITE_TYP_MS = 11'd5;
	localparam logic [10:0] NV_WRITE_MAX_MS = 11'd10;

	// Configuration field layout and factory values.
	localparam int CFG_WDOG_LSB = 0;
	localparam int CFG_POR_LSB  = 2;
	localparam logic [1:0] POR_SEL_RST  = 2'h1;
	localparam logic [1:0] WDOG_SEL_RST = 2'h3;
	localparam logic [1:0] WDOG_SEL_OFF = 2'h3;

	// Register byte offsets.
	localparam logic [7:0] REG_CFG      = 8'h00;
	localparam logic [7:0] REG_STATUS   = 8'h04;
	localparam logic [7:0] REG_INT_STAT = 8'h08;
	localparam logic [7:0] REG_INT_MASK = 8'h0C;

	// Interrupt bit positions.
	localparam int INT_W       = 4;
	localparam int INT_WDOG    = 0;
	localparam int INT_NV_DONE = 1;
	localparam int INT_SUPPLY  = 2;
	localparam int INT_BUS_WR  = 3;

	// Two-wire and AHB bus figures.
	localparam logic [3:0] BITS_PER_BYTE     = 4'd8;
	localparam logic [3:0] MISMATCH_SCL_CLKS = 4'd9;
	localparam logic [1:0] HTRANS_NONSEQ     = 2'h2;

	// Two-wire receiver states, Gray along idle, address, ack, data, data ack.
	typedef enum logic [2:0] {
		SVT_BS_IDLE = 3'h0,
		SVT_BS_ADDR = 3'h1,
		SVT_BS_ACK  = 3'h3,
		SVT_BS_DATA = 3'h2,
		SVT_BS_DACK = 3'h6,
		SVT_BS_SKIP = 3'h7
	} svt_bus_e;

	// Power-on reset delay in milliseconds for a select code.
	function automatic logic [10:0] svt_por_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    svt_por_ms = POR_MS_0;
			2'h1:    svt_por_ms = POR_MS_1;
			2'h2:    svt_por_ms = POR_MS_2;
			default: svt_por_ms = POR_MS_3;
		endcase
	endfunction

	// Watchdog period in milliseconds; the off code returns the shortest period.
	function automatic logic [10:0] svt_wdog_ms(input logic [1:0] sel);
		case (sel)
			2'h0:    svt_wdog_ms = WDOG_MS_0;
			2'h1:    svt_wdog_ms = WDOG_MS_1;
			default: svt_wdog_ms = WDOG_MS_2;
		endcase
	endfunction

endpackage

// ### svt_props.sv
/*
 * Port checker of the supervisor timing core, bound into svt_top.
 * Assumes one clock domain with the synchronous active-low rst_n.
 */
`timescale 1ns/1ps
module svt_props
	import svt_pkg::*;
#(
	parameter int TICK_CLKS = 10
) (
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        primary_trip_level,
	input wire logic        sys_reset_n,
	input wire logic        watchdog_alarm_out
);
	int lo_cnt;
	int hi_cnt;

	// Length of the running reset and alarm levels; a stuck timer shows as a short pulse.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lo_cnt <= 0;
			hi_cnt <= 0;
		end else begin
			lo_cnt <= sys_reset_n ? 0 : lo_cnt + 1;
			hi_cnt <= watchdog_alarm_out ? hi_cnt + 1 : 0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// A transfer taken on the register bus, and a read of an unmapped place.
	sequence s_taken;
		hsel && hready && htrans == HTRANS_NONSEQ;
	endsequence
	sequence s_unmapped_rd;
		s_taken ##0 (!hwrite && haddr[7:0] > REG_INT_MASK);
	endsequence

	// Zero wait states and an OKAY answer.
	a_ready_zero_wait: assert property (s_taken |=> hreadyout && !hresp)
		else $error("bus transfer stalled or not okay");
	// Unmapped places read zero.
	a_unmapped_zero: assert property (s_unmapped_rd |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_supply_drop: assert property (primary_trip_level |-> ##[0:500] !sys_reset_n)
		else $error("reset late after supply drop");
	a_supply_held: assert property (primary_trip_level [*8] |-> !sys_reset_n)
		else $error("reset released while supply low");
	a_por_length: assert property ($rose(sys_reset_n) |-> lo_cnt >= 49 * TICK_CLKS)
		else $error("power-on delay too short");
	a_alarm_width: assert property ($fell(watchdog_alarm_out) |->
		hi_cnt >= 24 * TICK_CLKS && hi_cnt <= 200 * TICK_CLKS + 2)
		else $error("alarm width out of range");
	a_ack_released: assert property ($rose(sda_oe) |-> ##[1:1000] !sda_oe)
		else $error("data line held too long");
	// Open-drain pin only pulls low.
	a_sda_open_drain: assert property (sda_oe |-> !sda_o)
		else $error("data pin driven high");
endmodule

bind svt_top svt_props #(.TICK_CLKS(TICK_CLKS)) u_props (.*);

// ### svt_top.sv
/*
 * Supervisor timing core: power-on and supply-fail reset, watchdog with restart on
 * a two-wire start condition, a write-only two-wire slave that updates the delay
 * and period selects through a self-timed nonvolatile write, and an AHB-Lite
 * register slave with a masked interrupt.
 * Assumes a free-running 100 MHz clk and that rst_n stands for power-on.
 * The bus pins and the supply comparator are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
// Operation
// R01: After a write ends with stop, run a self-timed nonvolatile write cycle, 10 ms max.
// R02: The bus master waits the write time, or polls for acknowledge.
// R03: Power-on reset delay select: 50, 200, 400 or 800 ms.
// R04: Power-on delay select resets to code 01, giving 200 ms.
// R05: Watchdog period select: 1.4 s, 200 ms, 25 ms, or off.
// R06: Watchdog period select resets to code 11, watchdog off.
// R07: Periods 00 and 01 hold the watchdog output for about 200 ms.
// R08: Period 10 holds the watchdog output for about 25 ms.
// R09: The host makes each restart pulse at least 1 us wide.
// R10: A supply drop below the trip level asserts reset within 5 us.
// R11: Bus input pulses narrower than 50 ns are ignored as glitches.
// R12: A wrong device select returns the slave to standby nine clocks after start.
// R13: At period end assert the watchdog output, then restart counting after timeout.
// R14: While the nonvolatile write runs, writes are ignored and the address not acknowledged.
module svt_top
	import svt_pkg::*;
#(
	parameter int         TICK_CLKS = svt_pkg::TICK_CYCLES,
	parameter logic [6:0] DEV_SEL   = 7'h2A
) (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        primary_trip_level,
	output logic             sys_reset_n,
	output logic             watchdog_alarm_out,
	output logic             irq
);
	import svt_pkg::*;

	logic             scl_f;
	logic             sda_f;
	logic             scl_q;
	logic             sda_q;
	logic             supply_low;
	logic             supply_low_q;
	logic [31:0]      tick_cnt_r;
	logic             tick_r;
	logic [1:0]       por_delay_sel_r;
	logic [1:0]       wdog_period_sel_r;
	logic             por_active_r;
	logic [MS_W-1:0]  por_ms_r;
	logic [MS_W-1:0]  wd_ms_r;
	logic             wd_fire;
	logic [MS_W-1:0]  wd_timeout_ms;
	svt_bus_e         bus_state_r;
	logic [3:0]       bit_cnt_r;
	logic [3:0]       clk_cnt_r;
	logic [7:0]       shift_r;
	logic [3:0]       pend_cfg_r;
	logic             wr_pend_r;
	logic             nv_busy_r;
	logic [MS_W-1:0]  nv_ms_r;
	logic             nv_commit;
	logic             start_cond;
	logic             stop_cond;
	logic             scl_rise;
	logic             scl_fall;
	logic             addr_ok;
	logic             ahb_wr_r;
	logic [7:0]       ahb_addr_r;
	logic             addr_phase;
	logic [INT_W-1:0] int_stat_r;
	logic [INT_W-1:0] int_mask_r;
	logic [INT_W-1:0] int_set;
	logic [INT_W-1:0] int_clr;

	// R11: glitch filters
	svt_deglitch #(.STABLE(GLITCH_CYCLES), .INIT(1'b1)) u_scl_filt (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_in    (scl_in),
		.level_out (scl_f)
	);
	svt_deglitch #(.STABLE(GLITCH_CYCLES), .INIT(1'b1)) u_sda_filt (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_in    (sda_in),
		.level_out (sda_f)
	);

	// R10: supply sense path
	// The comparator only needs synchronising; one filter cycle keeps latency tiny.
	svt_deglitch #(.STABLE(1), .INIT(1'b0)) u_supply_sync (
		.clk       (clk),
		.rst_n     (rst_n),
		.pin_in    (primary_trip_level),
		.level_out (supply_low)
	);

	// Previous filtered levels feed the edge and condition detectors.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_q        <= 1'b1;
			sda_q        <= 1'b1;
			supply_low_q <= 1'b0;
		end else begin
			scl_q        <= scl_f;
			sda_q        <= sda_f;
			supply_low_q <= supply_low;
		end
	end

	assign start_cond = scl_f & scl_q & sda_q & ~sda_f;
	assign stop_cond  = scl_f & scl_q & ~sda_q & sda_f;
	assign scl_rise   = scl_f & ~scl_q;
	assign scl_fall   = ~scl_f & scl_q;
	assign addr_ok    = (shift_r[7:1] == DEV_SEL) & ~shift_r[0];

	// One-millisecond enable; free running, so each delay may end up to one tick early.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b0;
		end else if (tick_cnt_r >= 32'(TICK_CLKS - 1)) begin
			tick_cnt_r <= 32'h0000_0000;
			tick_r     <= 1'b1;
		end else begin
			tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
			tick_r     <= 1'b0;
		end
	end

	// R04: factory delay select
	// R06: factory period select
	// Software writes take effect at once; a bus write lands at the end of its write cycle.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			por_delay_sel_r   <= POR_SEL_RST;
			wdog_period_sel_r <= WDOG_SEL_RST;
		end else if (nv_commit) begin
			por_delay_sel_r   <= pend_cfg_r[CFG_POR_LSB +: 2];
			wdog_period_sel_r <= pend_cfg_r[CFG_WDOG_LSB +: 2];
		end else if (ahb_wr_r && ahb_addr_r == REG_CFG) begin
			por_delay_sel_r   <= hwdata[CFG_POR_LSB +: 2];
			wdog_period_sel_r <= hwdata[CFG_WDOG_LSB +: 2];
		end
	end

	// R03: power-on delay
	// A supply drop restarts the full delay, so reset releases only after recovery.
	always_ff @(posedge clk) begin
		if (!rst_n || supply_low) begin
			por_active_r <= 1'b1;
			por_ms_r     <= '0;
		end else if (por_active_r && tick_r) begin
			if (por_ms_r >= svt_por_ms(por_delay_sel_r) - 11'd1) begin
				por_active_r <= 1'b0;
				por_ms_r     <= '0;
			end else begin
				por_ms_r <= por_ms_r + 11'd1;
			end
		end
	end

	// R10: reset output
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sys_reset_n <= 1'b0;
		end else begin
			sys_reset_n <= ~(por_active_r | supply_low);
		end
	end

	// R07: long timeout
	// R08: short timeout
	assign wd_timeout_ms = (wdog_period_sel_r == 2'h2) ? WDOG_RST2_MS : WDOG_RST1_MS;

	// R05: period select
	// R13: alarm then resume
	// A start condition on the bus restarts the count, since the host addresses us anyway.
	always_ff @(posedge clk) begin
		if (!rst_n || por_active_r || wdog_period_sel_r == WDOG_SEL_OFF) begin
			wd_ms_r            <= '0;
			watchdog_alarm_out <= 1'b0;
		end else if (watchdog_alarm_out) begin
			if (tick_r) begin
				if (wd_ms_r >= wd_timeout_ms - 11'd1) begin
					watchdog_alarm_out <= 1'b0;
					wd_ms_r            <= '0;
				end else begin
					wd_ms_r <= wd_ms_r + 11'd1;
				end
			end
		end else if (start_cond) begin
			wd_ms_r <= '0;
		end else if (tick_r) begin
			if (wd_ms_r >= svt_wdog_ms(wdog_period_sel_r) - 11'd1) begin
				watchdog_alarm_out <= 1'b1;
				wd_ms_r            <= '0;
			end else begin
				wd_ms_r <= wd_ms_r + 11'd1;
			end
		end
	end

	assign wd_fire = !por_active_r && wdog_period_sel_r != WDOG_SEL_OFF && !watchdog_alarm_out
		&& !start_cond && tick_r && wd_ms_r >= svt_wdog_ms(wdog_period_sel_r) - 11'd1;

	// Two-wire receiver: write only; a byte holds both selects in its low nibble.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bus_state_r <= SVT_BS_IDLE;
			bit_cnt_r   <= 4'h0;
			clk_cnt_r   <= 4'h0;
			shift_r     <= 8'h00;
			pend_cfg_r  <= 4'h0;
			wr_pend_r   <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (stop_cond) begin
			bus_state_r <= SVT_BS_IDLE;
			wr_pend_r   <= 1'b0;
			sda_oe      <= 1'b0;
		end else if (start_cond) begin
			bus_state_r <= SVT_BS_ADDR;
			bit_cnt_r   <= 4'h0;
			clk_cnt_r   <= 4'h0;
			wr_pend_r   <= 1'b0;
			sda_oe      <= 1'b0;
		end else begin
			case (bus_state_r)
				SVT_BS_IDLE: begin
					sda_oe <= 1'b0;
				end
				SVT_BS_ADDR: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
						clk_cnt_r <= clk_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
						// R14: no ack while busy
						// R02: enables ack polling
						if (addr_ok && !nv_busy_r) begin
							bus_state_r <= SVT_BS_ACK;
							sda_oe      <= 1'b1;
						end else begin
							bus_state_r <= SVT_BS_SKIP;
						end
					end
				end
				SVT_BS_ACK: begin
					if (scl_fall) begin
						sda_oe      <= 1'b0;
						bus_state_r <= SVT_BS_DATA;
						bit_cnt_r   <= 4'h0;
					end
				end
				SVT_BS_DATA: begin
					if (scl_rise) begin
						shift_r   <= {shift_r[6:0], sda_f};
						bit_cnt_r <= bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == BITS_PER_BYTE) begin
						bus_state_r <= SVT_BS_DACK;
						sda_oe      <= 1'b1;
						pend_cfg_r  <= shift_r[3:0];
						wr_pend_r   <= 1'b1;
					end
				end
				SVT_BS_DACK: begin
					if (scl_fall) begin
						sda_oe      <= 1'b0;
						bus_state_r <= SVT_BS_DATA;
						bit_cnt_r   <= 4'h0;
					end
				end
				SVT_BS_SKIP: begin
					// R12: standby after nine
					if (scl_rise) begin
						if (clk_cnt_r >= MISMATCH_SCL_CLKS - 4'h1) begin
							bus_state_r <= SVT_BS_IDLE;
						end else begin
							clk_cnt_r <= clk_cnt_r + 4'h1;
						end
					end
				end
				default: begin
					bus_state_r <= SVT_BS_IDLE;
					sda_oe      <= 1'b0;
				end
			endcase
		end
	end

	// Data output is always low; the pin is open-drain and only the enable moves.
	always_ff @(posedge clk) begin
		sda_o <= 1'b0;
	end

	// R01: self-timed write
	// The typical figure is used, which stays well inside the longest allowed time.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			nv_busy_r <= 1'b0;
			nv_ms_r   <= '0;
		end else if (!nv_busy_r && stop_cond && wr_pend_r) begin
			nv_busy_r <= 1'b1;
			nv_ms_r   <= '0;
		end else if (nv_busy_r && tick_r) begin
			if (nv_ms_r >= NV_WRITE_TYP_MS - 11'd1) begin
				nv_busy_r <= 1'b0;
				nv_ms_r   <= '0;
			end else begin
				nv_ms_r <= nv_ms_r + 11'd1;
			end
		end
	end

	assign nv_commit = nv_busy_r && tick_r && nv_ms_r >= NV_WRITE_TYP_MS - 11'd1;

	// AHB-Lite address phase: zero wait states, so hready high marks a taken phase.
	assign addr_phase = hsel && hready && htrans == HTRANS_NONSEQ;

	// Latch the write for its data phase, where hwdata stands.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ahb_wr_r   <= 1'b0;
			ahb_addr_r <= 8'h00;
		end else begin
			ahb_wr_r   <= addr_phase && hwrite;
			ahb_addr_r <= addr_phase ? haddr[7:0] : ahb_addr_r;
		end
	end

	// Read data is registered at the address edge; unmapped words read as zero.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hrdata <= 32'h0000_0000;
		end else if (addr_phase && !hwrite) begin
			case (haddr[7:0])
				REG_CFG:      hrdata <= {28'h0, por_delay_sel_r, wdog_period_sel_r};
				REG_STATUS:   hrdata <= {24'h0, bus_state_r, nv_busy_r, supply_low,
					watchdog_alarm_out, por_active_r, ~sys_reset_n};
				REG_INT_STAT: hrdata <= {28'h0, int_stat_r};
				REG_INT_MASK: hrdata <= {28'h0, int_mask_r};
				default:      hrdata <= 32'h0000_0000;
			endcase
		end
	end

	// The slave holds hreadyout low in reset, then never stalls and always answers OKAY.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			hreadyout <= 1'b0;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

	// Interrupt events: a set in the same cycle as its clear wins.
	always_comb begin
		int_set              = '0;
		int_set[INT_WDOG]    = wd_fire;
		int_set[INT_NV_DONE] = nv_commit;
		int_set[INT_SUPPLY]  = supply_low & ~supply_low_q;
		int_set[INT_BUS_WR]  = stop_cond & wr_pend_r & ~nv_busy_r;
		int_clr = (ahb_wr_r && ahb_addr_r == REG_INT_STAT) ? hwdata[INT_W-1:0] : '0;
	end

	// Sticky status and mask registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			int_stat_r <= '0;
			int_mask_r <= '0;
		end else begin
			int_stat_r <= (int_stat_r & ~int_clr) | int_set;
			if (ahb_wr_r && ahb_addr_r == REG_INT_MASK) begin
				int_mask_r <= hwdata[INT_W-1:0];
			end
		end
	end

	// Level interrupt, one cycle behind the status it reflects.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_stat_r & int_mask_r);
		end
	end

endmodule

// ### svt_top_tb.sv
/*
 * Self-checking bench of the supervisor timing core with a two-wire host.
 * Assumes a tick of 80 clk cycles, so 1 ms of the device is 80 cycles here.
 */
`timescale 1ns/1ps
module svt_top_tb;
	import svt_pkg::*;
	localparam int         T   = 80;
	localparam logic [6:0] DEV = 7'h2A; // Bus address, arbitrary.
	logic        clk;
	logic        rst_n;
	logic        hsel;
	logic        hwrite;
	logic        trip;
	logic        hreadyout;
	logic        hresp;
	logic        scl;
	logic        sda;
	logic        sda_o;
	logic        sda_oe;
	logic        rst_out_n;
	logic        alarm;
	logic        irq;
	logic        aa;
	logic        ad;
	logic [1:0]  htrans;
	logic [7:0]  ua;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic [31:0] rd_data;
	logic [31:0] exp_q[$];
	int          errors = 0;
	int          n_compared = 0;
	int          cyc = 0;
	int          n;
	int          f;
	event        rd_ev;

	svt_top #(.TICK_CLKS(T), .DEV_SEL(DEV)) u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_in(scl), .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.primary_trip_level(trip), .sys_reset_n(rst_out_n),
		.watchdog_alarm_out(alarm), .irq(irq));
	svt_host u_host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
		n_compared++;
		if (g < lo || g > hi) begin
			errors++;
			$display("wrong value %s expected %0d..%0d seen %0d", nm, lo, hi, g);
		end
	endtask

	task automatic end_sim();
		$display("mismatches %0d of %0d compared", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// One single AHB transfer; the master waits for ready in both phases.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd_data = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		ahb(1'b0, a, 32'h0);
		->rd_ev;
	endtask

	// Cycles until reset output (sel 1) or alarm (sel 0) reaches a level.
	task automatic wt(input logic sel, input logic lvl, output int k);
		k = 0;
		while ((sel ? rst_out_n : alarm) !== lvl && k < 40000) begin
			@(posedge clk);
			k++;
		end
	endtask

	// Every read result is matched against the oldest expectation.
	initial forever begin
		@(rd_ev);
		chk("read data", exp_q.pop_front(), rd_data);
	end

	// The whole run needs about 52000 cycles; a hang ends here.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc > 90000) begin
			errors++;
			end_sim();
		end
	end

	initial begin
		rst_n = 1'b0;
		hsel = 1'b0;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		trip = 1'b0;
		void'($urandom(32'h3C9EE70F));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		wt(1'b1, 1'b1, n);
		chk_rng("power-on delay", 199 * T, 200 * T + 4, n);
		rd(REG_CFG, 32'h7);
		rd(REG_INT_STAT, 32'h0);
		ua = 8'($urandom_range(4, 63) * 4);
		ahb(1'b1, ua, $urandom);
		rd(ua, 32'h0);
		ahb(1'b1, REG_INT_MASK, 32'h1);
		for (int c = 2; c >= 1; c--) begin
			ahb(1'b1, REG_CFG, 32'h4 | c);
			wt(1'b0, 1'b1, n);
			repeat (2) @(posedge clk);
			chk("irq", 32'h1, {31'h0, irq});
			wt(1'b0, 1'b0, n);
			chk_rng("alarm width", (c == 2 ? 24 : 199) * T, (c == 2 ? 25 : 200) * T + 4, n);
			if (c == 2) begin
				f = cyc;
				repeat (600) @(posedge clk);
				u_host.glitch();
				wt(1'b0, 1'b1, n);
				chk_rng("alarm period", 24 * T, 25 * T + 4, cyc - f);
			end
		end
		ahb(1'b1, REG_INT_MASK, 32'h0);
		// The mask lands at the data edge and irq follows one edge later.
		repeat (2) @(posedge clk);
		chk("masked irq", 32'h0, {31'h0, irq});
		ahb(1'b1, REG_INT_STAT, 32'h1);
		rd(REG_INT_STAT, 32'h0);
		ahb(1'b1, REG_CFG, 32'h6);
		wt(1'b0, 1'b1, n);
		wt(1'b0, 1'b0, n);
		repeat (600) @(posedge clk);
		f = cyc;
		u_host.xfer({~DEV, 1'b0}, 8'h0, aa, ad);
		chk("wrong address ack", 32'h0, {31'h0, aa});
		wt(1'b0, 1'b1, n);
		chk_rng("restarted period", 24 * T, 25 * T + 30, cyc - f);
		// Let the alarm run out, since the coming write turns the watchdog off.
		wt(1'b0, 1'b0, n);
		chk_rng("short alarm width", 24 * T, 25 * T + 4, n);
		ahb(1'b1, REG_INT_STAT, 32'hF);
		u_host.xfer({DEV, 1'b0}, {4'($urandom), 4'h3}, aa, ad);
		chk("write acks", 32'h3, {30'h0, aa, ad});
		u_host.xfer({DEV, 1'b0}, 8'h0, aa, ad);
		chk("busy ack", 32'h0, {31'h0, aa});
		repeat (10 * T) @(posedge clk);
		rd(REG_CFG, 32'h3);
		trip <= 1'b1;
		wt(1'b1, 1'b0, n);
		chk_rng("supply reset", 0, 500, n);
		repeat (20) @(posedge clk);
		trip <= 1'b0;
		wt(1'b1, 1'b1, n);
		chk_rng("delay after drop", 49 * T, 50 * T + 8, n);
		rd(REG_INT_STAT, 32'hE);
		// One edge lets the compare process take the last read before the verdict.
		@(posedge clk);
		end_sim();
	end
endmodule
